// [logic/adc_serial_readout.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout
   import adc_serial_pkg::*;
#(
   parameter int CONV_CYC = CONV_CYC_DEF,
   parameter int SCK_HALF = SCK_HALF_CYC
) (
   input  wire logic                   core_clk_i,            // Core clock, 20 MHz
   input  wire logic                   rst_i,                 // Async reset, high
   input  wire logic                   clock_source_select_i, // Pin: 1 internal SCK
   input  wire logic                   cs_n_i,                // Pin: chip select, low
   input  wire logic                   sck_i,                 // SCK pin input, link clock
   output logic                        sck_o,                 // SCK pin drive value
   output logic                        sck_oe_o,              // SCK pin enable
   input  wire logic                   sdi_i,                 // Serial config input
   output logic                        sdo_o,                 // Serial data value
   output logic                        sdo_oe_o,              // Serial data enable
   output logic                        busy_o,                // Converting
   input  wire logic [RESULT_BITS-1:0] result_i,              // Conversion result
   output cfg_t                        cfg_o                  // Active configuration
);

   core_state_t q;
   core_state_t n;
   link_rise_t  lr_q;
   link_rise_t  lr_n;
   link_fall_t  lf_q;
   link_fall_t  lf_n;

   logic int_mode_s;
   logic cs_s;
   logic sdi_s;
   logic link_end_s;
   logic ab_ok_s;
   logic cfg_ok_s;
   logic ext_mode;
   logic cs_rise;
   logic lnk_clr;
   logic link_end;
   logic start_conv;
   logic take_cfg;
   logic [12:0] cfg_word;

   // Pins and link levels into the core domain
   // Select resets as deselected: no output drive and no false edge after reset
   adc_sync2 #(.W(3), .RST_VAL(3'h2)) u_sync_pins (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .d_i   ({clock_source_select_i, cs_n_i, sdi_i}),
      .q_o   ({int_mode_s, cs_s, sdi_s})
   );

   adc_sync2 #(.W(3)) u_sync_link (
      .clk_i (core_clk_i),
      .rst_i (rst_i),
      .d_i   ({link_end, lf_q.fall_cnt >= ABORT_FALL, lr_q.rise_cnt >= CFG_RISES}),
      .q_o   ({link_end_s, ab_ok_s, cfg_ok_s})
   );

   assign ext_mode = ~int_mode_s;
   assign cs_rise  = cs_s & ~q.cs_q;

   // Link side runs on host SCK only while armed in sleep; SCK may stop anywhere
   assign lnk_clr  = rst_i | ~q.arm;
   assign link_end = lf_q.fall_cnt == FRAME_END;

   always_comb begin
      lr_n = lr_q;
      if (lr_q.rise_cnt < CFG_RISES) begin
         lr_n.cfg_sh = {lr_q.cfg_sh[11:0], sdi_i};
      end
      if (lr_q.rise_cnt < FRAME_END) begin
         lr_n.rise_cnt = lr_q.rise_cnt + 6'h01;
      end
   end

   always_ff @(posedge sck_i or posedge lnk_clr) begin
      if (lnk_clr) begin
         lr_q <= '0;
      end else begin
         lr_q <= lr_n;
      end
   end

   always_comb begin
      lf_n = lf_q;
      if (lf_q.fall_cnt < FRAME_END) begin
         lf_n.fall_cnt = lf_q.fall_cnt + 6'h01;
      end
      // Frame is stable while armed, so no crossing needed for it
      lf_n.sdo = frame_bit(q.frame, lf_n.fall_cnt);
   end

   // Cleared value shows status 0, the first frame bit
   always_ff @(negedge sck_i or posedge lnk_clr) begin
      if (lnk_clr) begin
         lf_q <= '0;
      end else begin
         lf_q <= lf_n;
      end
   end

   always_comb begin
      n          = q;
      n.cs_q     = cs_s;
      start_conv = 1'b0;
      take_cfg   = 1'b0;
      cfg_word   = q.cfg_sh;
      unique case (q.st)
         ST_CONV: begin
            n.sck = 1'b1;
            n.sdo = 1'b1;
            if (q.conv_ctr == 16'(CONV_CYC - 1)) begin
               n.conv_ctr = 16'h0000;
               n.frame    = {1'b0, result_i};
               n.st       = ST_SLEEP;
               n.sck      = 1'b0;
               n.sdo      = 1'b0;
            end else begin
               n.conv_ctr = q.conv_ctr + 16'h0001;
            end
         end
         ST_SLEEP: begin
            if (ext_mode) begin
               cfg_word = lr_q.cfg_sh;
               if (link_end_s) begin
                  start_conv = 1'b1;
                  take_cfg   = cfg_ok_s;
               end else if (cs_rise) begin
                  if (ab_ok_s) begin
                     start_conv = 1'b1;
                     take_cfg   = cfg_ok_s;
                  end else begin
                     n.st = ST_REARM;
                  end
               end
            end else if (!cs_s) begin
               n.st      = ST_TEST;
               n.tst_ctr = 4'h0;
               n.sck     = 1'b0;
            end
         end
         ST_REARM: begin
            n.st = ST_SLEEP;
         end
         ST_TEST: begin
            if (cs_s) begin
               n.st = ST_SLEEP;
            end else if (q.tst_ctr == 4'(STATUS_TEST_CYC - 1)) begin
               n.st       = ST_SHIFT;
               n.sck      = 1'b1;
               n.rcnt     = 6'h01;
               n.bcnt     = 6'h00;
               n.half_ctr = 4'h0;
               n.cfg_sh   = {q.cfg_sh[11:0], sdi_s};
            end else begin
               n.tst_ctr = q.tst_ctr + 4'h1;
            end
         end
         ST_SHIFT: begin
            if (cs_s) begin
               start_conv = 1'b1;
               take_cfg   = q.rcnt >= CFG_RISES;
            end else if (q.half_ctr == 4'(SCK_HALF - 1)) begin
               n.half_ctr = 4'h0;
               if (q.sck && q.rcnt == FRAME_END) begin
                  // SCK stays high after the last rise, into the conversion
                  start_conv = 1'b1;
                  take_cfg   = 1'b1;
               end else if (q.sck) begin
                  n.sck  = 1'b0;
                  n.bcnt = q.bcnt + 6'h01;
                  n.sdo  = frame_bit(q.frame, q.bcnt + 6'h01);
               end else begin
                  n.sck = 1'b1;
                  if (q.rcnt < CFG_RISES) begin
                     n.cfg_sh = {q.cfg_sh[11:0], sdi_s};
                  end
                  n.rcnt = q.rcnt + 6'h01;
               end
            end else begin
               n.half_ctr = q.half_ctr + 4'h1;
            end
         end
      endcase
      if (start_conv) begin
         n.st       = ST_CONV;
         n.conv_ctr = 16'h0000;
         n.sck      = 1'b1;
         n.sdo      = 1'b1;
         if (take_cfg) begin
            n.cfg = cfg_t'(cfg_word);
         end
      end
      n.arm = (n.st == ST_SLEEP) & ext_mode;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q       <= '0;
         q.st    <= ST_CONV;
         q.sck   <= 1'b1;
         q.sdo   <= 1'b1;
         q.cs_q  <= 1'b1;
         q.cfg   <= cfg_t'(CFG_RST);
         q.frame <= 32'hFFFFFFFF;
      end else begin
         q <= n;
      end
   end

   // Status out only while select low; link bit while armed
   assign sdo_o    = ((q.st == ST_SLEEP) & ext_mode) ? lf_q.sdo : q.sdo;
   assign sdo_oe_o = ~cs_s;
   // Link end term lifts busy on the 32nd fall before the core reacts
   assign busy_o   = (q.st == ST_CONV) | (q.arm & link_end);
   assign sck_o    = q.sck;
   assign sck_oe_o = int_mode_s;
   assign cfg_o    = q.cfg;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_sdo_hiz: assert property (cs_s |-> !sdo_oe_o)
      else $error("serial output driven while deselected");
   chk_busy_status: assert property ((q.st == ST_CONV) |-> (busy_o && sdo_o))
      else $error("busy or status low while converting");
   chk_sleep_entry: assert property (
      (q.st == ST_CONV && q.conv_ctr == 16'(CONV_CYC - 1))
      |=> (q.st == ST_SLEEP && !busy_o && q.frame == {1'b0, $past(result_i)}))
      else $error("conversion end did not load result and sleep");
   chk_test_delay: assert property (
      $rose(q.st == ST_SHIFT)
      |-> ($past(q.st == ST_TEST) && $past(q.tst_ctr) == 4'(STATUS_TEST_CYC - 1) && sck_o))
      else $error("internal frame started without status test delay");
   chk_int_end: assert property (
      (q.st == ST_SHIFT && !cs_s && q.sck && q.rcnt == FRAME_END
      && q.half_ctr == 4'(SCK_HALF - 1)) |=> (q.st == ST_CONV && sck_o && sdo_o && busy_o))
      else $error("internal frame end wrong");
   chk_int_abort: assert property ((q.st == ST_SHIFT && cs_s) |=> (q.st == ST_CONV))
      else $error("internal abort did not start conversion");
   chk_ext_done: assert property (
      (q.st == ST_SLEEP && ext_mode && link_end_s)
      |=> (q.st == ST_CONV && busy_o))
      else $error("external frame end did not start conversion");
   // Window flag is judged as it stood at the select edge
   chk_ext_abort: assert property (
      (q.st == ST_SLEEP && ext_mode && !link_end_s && cs_rise)
      |=> ($past(ab_ok_s) ? q.st == ST_CONV : q.st == ST_REARM) ##1 (q.st != ST_REARM))
      else $error("external abort window handled wrong");
   chk_cfg_keep: assert property ((q.cfg != $past(q.cfg)) |-> $past(take_cfg && start_conv))
      else $error("configuration changed without full word");
   chk_sck_low: assert property ((int_mode_s && q.st == ST_TEST) |-> !sck_o)
      else $error("internal SCK not low after select fell");
   chk_ext_armed: assert property ((q.st == ST_SLEEP && ext_mode) |-> q.arm)
      else $error("external link not armed in sleep");
   chk_rearm_back: assert property ((q.st == ST_REARM) |=> (q.st == ST_SLEEP))
      else $error("early select rise left sleep");
   chk_shift_bit: assert property (
      (q.st == ST_SHIFT && $fell(q.sck)) |-> (sdo_o == frame_bit(q.frame, q.bcnt)))
      else $error("internal frame bit wrong");
   chk_int_idle: assert property (
      (int_mode_s && q.st == ST_SLEEP) |-> (!sck_o && !busy_o))
      else $error("internal SCK or busy high in sleep");
   chk_busy_frame: assert property ((q.st == ST_TEST || q.st == ST_SHIFT) |-> !busy_o)
      else $error("busy high during readout");

   cov_ext_frame: cover property (q.st == ST_SLEEP && ext_mode && link_end_s);
   cov_ext_abort: cover property (q.st == ST_SLEEP && ext_mode && cs_rise && ab_ok_s);
   cov_int_frame: cover property (q.st == ST_SHIFT && q.rcnt == FRAME_END ##1 q.st == ST_CONV);
   cov_int_abort: cover property (q.st == ST_SHIFT && cs_s);

endmodule : adc_serial_readout
`default_nettype wire

// [logic/adc_serial_pkg.sv]
package adc_serial_pkg;

   localparam int CLK_PERIOD_NS        = 50;
   localparam int STATUS_TEST_DELAY_NS = 500;
   // Least time, rounded up to whole core cycles
   localparam int STATUS_TEST_CYC      = (STATUS_TEST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF_CYC         = 4;
   localparam int CONV_CYC_DEF         = 64;

   localparam int FRAME_BITS           = 32;
   localparam int RESULT_BITS          = 31;
   localparam int CFG_BITS             = 13;
   localparam int ABORT_MIN_FALL       = 5;

   localparam logic [5:0]  FRAME_END   = 6'h20;
   localparam logic [5:0]  LAST_RISE   = 6'h1F;
   localparam logic [5:0]  CFG_RISES   = 6'h0D;
   localparam logic [5:0]  ABORT_FALL  = 6'h05;
   localparam logic [12:0] CFG_RST     = 13'h0000;

   typedef enum logic [4:0] {
      ST_CONV  = 5'h01,
      ST_SLEEP = 5'h02,
      ST_REARM = 5'h04,
      ST_TEST  = 5'h08,
      ST_SHIFT = 5'h10
   } core_st_t;

   typedef struct packed {
      logic [7:0] channel;
      logic [3:0] rate;
      logic       double_rate_select;
   } cfg_t;

   typedef struct packed {
      core_st_t    st;
      logic [15:0] conv_ctr;
      logic [3:0]  tst_ctr;
      logic [3:0]  half_ctr;
      logic [5:0]  rcnt;
      logic [5:0]  bcnt;
      logic        sck;
      logic        sdo;
      logic        arm;
      logic        cs_q;
      logic [12:0] cfg_sh;
      cfg_t        cfg;
      logic [31:0] frame;
   } core_state_t;

   typedef struct packed {
      logic [5:0]  rise_cnt;
      logic [12:0] cfg_sh;
   } link_rise_t;

   typedef struct packed {
      logic [5:0] fall_cnt;
      logic       sdo;
   } link_fall_t;

   // Bit shown on the serial output after idx falling edges
   function automatic logic frame_bit(input logic [31:0] frame, input logic [5:0] idx);
      logic b;
      b = 1'b1;
      if (idx < FRAME_END) begin
         b = frame[5'h1F - idx[4:0]];
      end
      return b;
   endfunction : frame_bit

endpackage : adc_serial_pkg

// [logic/adc_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_sync2 #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0  // Level shown during reset
) (
   input  wire logic         clk_i,  // Destination clock
   input  wire logic         rst_i,  // Async reset, high
   input  wire logic [W-1:0] d_i,    // Foreign level
   output logic      [W-1:0] q_o     // Synchronised level
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end

   assign q_o = q_r;
endmodule : adc_sync2
`default_nettype wire

// [tb/adc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
   output logic      sck_o,      // Host SCK drive
   output logic      sdi_o,      // Config bit out
   input  wire logic sck_line_i, // SCK wire level
   input  wire logic sdo_line_i  // SDO wire level
);
   initial sck_o = 1'b0;
   initial sdi_o = 1'b0;
   // Link clock of 48 ns, still between frames
   task automatic ext_frame(input int n, input logic [12:0] c, output logic [31:0] g);
      g = 32'h0;
      for (int i = 0; i < n; i++) begin
         sdi_o = (i < 13) ? c[12 - i] : ~sdi_o;
         #24 sck_o = 1'b1;
         g = {g[30:0], sdo_line_i};
         #24 sck_o = 1'b0;
      end
   endtask : ext_frame
   // SDI is synchronised inside, so set it by the fall before
   task automatic int_frame(input int n, input logic [12:0] c, output logic [31:0] g);
      g = 32'h0;
      sdi_o = c[12];
      for (int i = 0; i < n; i++) begin
         @(posedge sck_line_i);
         g = {g[30:0], sdo_line_i};
         if (i < n - 1) begin
            @(negedge sck_line_i);
            sdi_o = (i < 12) ? c[11 - i] : ~sdi_o;
         end
      end
   endtask : int_frame
endmodule : adc_host_model
`default_nettype wire

// [tb/adc_serial_readout_timing_modes_test.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_timing_modes_test;
   import adc_serial_pkg::*;
   logic                   core_clk_i = 1'b0;
   logic                   rst_i      = 1'b1;
   logic                   sel        = 1'b0;
   logic                   cs_n       = 1'b1;
   logic                   sdo_q      = 1'b0;
   logic                   sck_dev, sck_oe, sdo, sdo_oe, busy;
   wire logic              host_sck, host_sdi, sck_line, sdo_line;
   logic [RESULT_BITS-1:0] result     = '0;
   cfg_t                   cfg;
   int                     n_errors        = 0;
   int                     samples_checked = 0;
   int                     cyc             = 0;
   logic [15:0]            rnd        = 16'h0049;
   logic [12:0]            exp_cfg    = 13'h0000;
   logic [12:0]            new_cfg;
   logic [31:0]            got;
   logic [31:0]            exp_frame;
   logic [31:0]            held_q[$];

   // Released SDO shows the inverse of its last driven bit
   assign sck_line = sck_oe ? sck_dev : host_sck;
   assign sdo_line = sdo_oe ? sdo : ~sdo_q;

   adc_serial_readout #(.CONV_CYC(8), .SCK_HALF(4)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .clock_source_select_i(sel),
      .cs_n_i(cs_n), .sck_i(sck_line), .sck_o(sck_dev), .sck_oe_o(sck_oe),
      .sdi_i(host_sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .busy_o(busy),
      .result_i(result), .cfg_o(cfg));

   adc_host_model host (
      .sck_o(host_sck), .sdi_o(host_sdi), .sck_line_i(sck_line), .sdo_line_i(sdo_line));

   always #25 core_clk_i = ~core_clk_i;

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (sdo_oe === 1'b1) sdo_q <= sdo;
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   // Reference model: each conversion end holds status 0 and the result
   always @(negedge busy) begin
      if (rst_i === 1'b0) begin
         held_q.push_back({1'b0, result});
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #2;
   endtask : step

   // Bounded wait for the busy level, then compared
   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (busy !== lvl && k < 400) begin
         step(1);
         k++;
      end
      chk({31'h0, busy}, {31'h0, lvl});
   endtask : wait_busy

   // New values while converting; result taken at conversion end
   task automatic new_vals();
      rnd = lfsr(rnd);
      result = {rnd[14:0], rnd};
      rnd = lfsr(rnd);
      new_cfg = rnd[12:0];
   endtask : new_vals

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   initial begin
      new_vals();
      repeat (6) @(posedge core_clk_i);
      #2 rst_i = 1'b0;
      chk({31'h0, sdo_oe}, 32'h0);
      chk({19'h0, cfg}, 32'h0);
      // External clock, select held low across the frame
      cs_n = 1'b0;
      step(3);
      chk({30'h0, sdo, busy}, 32'h3);
      wait_busy(1'b0);
      chk({30'h0, sdo, sck_oe}, 32'h0);
      host.ext_frame(32, new_cfg, got);
      exp_frame = held_q[$];
      chk(got, exp_frame);
      #5 chk({30'h0, sdo, busy}, 32'h3);
      exp_cfg = new_cfg;
      new_vals();
      step(6);
      chk({19'h0, cfg}, {19'h0, exp_cfg});
      cs_n = 1'b1;
      step(3);
      chk({31'h0, sdo_oe}, 32'h0);
      $display("test external full frame done");
      // External abort after 8 falls keeps old config
      wait_busy(1'b0);
      cs_n = 1'b0;
      step(3);
      host.ext_frame(8, new_cfg, got);
      step(1);
      cs_n = 1'b1;
      step(4);
      chk({31'h0, busy}, 32'h1);
      exp_frame = held_q[$];
      chk({24'h0, got[7:0]}, {24'h0, exp_frame[31:24]});
      step(10);
      chk({19'h0, cfg}, {19'h0, exp_cfg});
      $display("test external abort done");
      // Internal clock, select tied low: frames start by themselves
      sel = 1'b1;
      step(4);
      chk({31'h0, sck_oe}, 32'h1);
      cs_n = 1'b0;
      step(3);
      host.int_frame(32, new_cfg, got);
      exp_frame = held_q[$];
      chk(got, exp_frame);
      exp_cfg = new_cfg;
      step(8);
      chk({29'h0, sck_dev, sdo, busy}, 32'h7);
      chk({19'h0, cfg}, {19'h0, exp_cfg});
      $display("test internal frame done");
      // Internal abort after 5 rises
      new_vals();
      host.int_frame(5, new_cfg, got);
      exp_frame = held_q[$];
      chk({27'h0, got[4:0]}, {27'h0, exp_frame[31:27]});
      cs_n = 1'b1;
      step(4);
      chk({31'h0, busy}, 32'h1);
      step(12);
      chk({19'h0, cfg}, {19'h0, exp_cfg});
      $display("test internal abort done");
      finish_test();
   end

endmodule : adc_serial_readout_timing_modes_test
`default_nettype wire
